//--- hdl/irqw_top.sv
// Purpose: Interrupt control, vectoring, reset and wake-up state
// Assumes: Core pulses arrive on this clock; pins are asynchronous
// Notes:   Registers are reached over Avalon-MM with waitrequest
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "irqw_consts.svh"

module irqw_top #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire irqw_pkg::irqw_rst_kind_t rst_kind,
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    ext_irq_pin,
  input  wire logic [7:0]              portb_pins,
  input  wire logic                    t0_tick,
  input  wire logic [7:0]              periph_evt_a,
  input  wire logic [7:0]              periph_evt_b,
  input  wire logic                    instr_boundary,
  input  wire logic                    return_from_irq_instr,
  input  wire logic                    sleep_enter,
  input  wire logic                    wdt_wake,
  output logic                         irq_pending,
  output logic                         stack_push,
  output logic                         pc_load,
  output logic      [12:0]             pc_value,
  output logic                         core_wake,
  output logic                         core_asleep
);

  logic [8:0]  pins_s;
  logic [7:0]  tmr_count;
  logic        t0_wrap;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_done, rd_start;
  logic [7:0]  ctl_r, ctl_nxt;
  logic [7:0]  fla_r, fla_nxt, flb_r, flb_nxt;
  logic [7:0]  ena_r, ena_nxt, enb_r, enb_nxt;
  logic [8:0]  cfg_r, cfg_nxt;
  logic [7:0]  sts_r, sts_nxt;
  logic [3:0]  pwr_r, pwr_nxt;
  logic [8:0]  prev_r, prev_nxt;
  irqw_pkg::irqw_state_t state_r, state_nxt;
  logic        pend_r, pend_nxt, push_r, push_nxt;
  logic        pcl_r, pcl_nxt, wake_r, wake_nxt, slp_r, slp_nxt;
  logic [12:0] pcv_r, pcv_nxt;
  logic        int_evt, rb_evt, any_en, gie_clr_now, take;

  function automatic logic hit(input logic en, input logic [5:0] a,
                               input logic [5:0] off);
    return en && (a == off);
  endfunction

  irqw_sync #(
    .W      (9),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({ext_irq_pin, portb_pins}),
    .sync_out (pins_s)
  );

  irqw_timer0 #(
    .W (8)
  ) u_tmr (
    .clock    (clock),
    .rst      (rst),
    .tick     (t0_tick),
    .load     (hit(wr_done, avs_address, `IRQW_ADR_TMR)),
    .load_val (avs_writedata[7:0]),
    .count    (tmr_count),
    .wrap     (t0_wrap)
  );

  // Bus slave: one wait cycle, then a one-cycle answer
  always_comb begin
    wr_done   = avs_write && !wait_r;
    rd_start  = avs_read && wait_r;
    wait_nxt  = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    if (rd_start) begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address)
        `IRQW_ADR_CTL: rdata_nxt[7:0] = ctl_r;
        `IRQW_ADR_FLA: rdata_nxt[7:0] = fla_r;
        `IRQW_ADR_FLB: rdata_nxt[7:0] = flb_r;
        `IRQW_ADR_ENA: rdata_nxt[7:0] = ena_r;
        `IRQW_ADR_ENB: rdata_nxt[7:0] = enb_r;
        `IRQW_ADR_PWR: rdata_nxt[3:0] = pwr_r;
        `IRQW_ADR_STS: rdata_nxt[7:0] = sts_r;
        `IRQW_ADR_CFG: rdata_nxt[8:0] = cfg_r;
        `IRQW_ADR_TMR: rdata_nxt[7:0] = tmr_count;
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (rst) begin
      wait_nxt  = 1'b1;
      rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    wait_r  <= wait_nxt;
    rdata_r <= rdata_nxt;
  end

  // Event detection, request and take decision
  always_comb begin
    prev_nxt = pins_s;
    int_evt  = cfg_r[`IRQW_CFG_EDGE] ? (pins_s[8] && !prev_r[8]) :
                                       (!pins_s[8] && prev_r[8]);
    rb_evt   = |((pins_s[7:0] ^ prev_r[7:0]) & cfg_r[7:0]);
    any_en   = (ctl_r[`IRQW_T0IE] && ctl_r[`IRQW_TIMER0_WRAP_FLAG]) ||
               (ctl_r[`IRQW_INTE] && ctl_r[`IRQW_PIN_IRQ_FLAG]) ||
               (ctl_r[`IRQW_RBIE] && ctl_r[`IRQW_RBIF]) ||
               (ctl_r[`IRQW_PEIE] &&
                (|((fla_r & ena_r) | (flb_r & enb_r))));
    gie_clr_now = hit(wr_done, avs_address, `IRQW_ADR_CTL) &&
                  !avs_writedata[`IRQW_GIE];
    take = instr_boundary && (state_r == irqw_pkg::IRQW_RUN) &&
           ctl_r[`IRQW_GIE] && any_en && !gie_clr_now;
  end

  // Flag, enable and configuration registers
  always_comb begin
    ctl_nxt = ctl_r;
    fla_nxt = fla_r;
    flb_nxt = flb_r;
    ena_nxt = ena_r;
    enb_nxt = enb_r;
    cfg_nxt = cfg_r;
    if (hit(wr_done, avs_address, `IRQW_ADR_CTL)) begin
      ctl_nxt = avs_writedata[7:0];
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_FLA)) begin
      fla_nxt = avs_writedata[7:0];
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_FLB)) begin
      flb_nxt = avs_writedata[7:0];
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_ENA)) begin
      ena_nxt = avs_writedata[7:0] & `IRQW_FLA_MASK;
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_ENB)) begin
      enb_nxt = avs_writedata[7:0] & `IRQW_FLB_MASK;
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_CFG)) begin
      cfg_nxt = avs_writedata[8:0];
    end
    if (return_from_irq_instr) begin
      ctl_nxt[`IRQW_GIE] = 1'b1;
    end
    if (take) begin
      ctl_nxt[`IRQW_GIE] = 1'b0;
    end
    // Events win over a software clear in the same cycle
    if (int_evt) begin
      ctl_nxt[`IRQW_PIN_IRQ_FLAG] = 1'b1;
    end
    if (t0_wrap) begin
      ctl_nxt[`IRQW_TIMER0_WRAP_FLAG] = 1'b1;
    end
    if (rb_evt) begin
      ctl_nxt[`IRQW_RBIF] = 1'b1;
    end
    fla_nxt = (fla_nxt | periph_evt_a) & `IRQW_FLA_MASK;
    flb_nxt = (flb_nxt | periph_evt_b) & `IRQW_FLB_MASK;
    if (rst) begin
      ctl_nxt = `IRQW_CTL_RST;
      fla_nxt = 8'h00;
      flb_nxt = 8'h00;
      ena_nxt = 8'h00;
      enb_nxt = 8'h00;
      cfg_nxt = `IRQW_CFG_RST;
    end
  end

  always_ff @(posedge clock) begin
    prev_r <= prev_nxt;
    ctl_r  <= ctl_nxt;
    fla_r  <= fla_nxt;
    flb_r  <= flb_nxt;
    ena_r  <= ena_nxt;
    enb_r  <= enb_nxt;
    cfg_r  <= cfg_nxt;
  end

  // Sleep, wake, reset patterns and core controls
  always_comb begin
    state_nxt = state_r;
    sts_nxt   = sts_r;
    pwr_nxt   = pwr_r;
    wake_nxt  = 1'b0;
    if (hit(wr_done, avs_address, `IRQW_ADR_STS)) begin
      sts_nxt = (avs_writedata[7:0] & `IRQW_STS_WMASK) |
                (sts_r & ~`IRQW_STS_WMASK);
    end
    if (hit(wr_done, avs_address, `IRQW_ADR_PWR)) begin
      pwr_nxt = avs_writedata[3:0];
    end
    case (state_r)
      irqw_pkg::IRQW_RUN: begin
        if (sleep_enter) begin
          state_nxt = irqw_pkg::IRQW_SLEEP;
        end
      end
      irqw_pkg::IRQW_SLEEP: begin
        if (wdt_wake) begin
          state_nxt = irqw_pkg::IRQW_RUN;
          wake_nxt  = 1'b1;
          sts_nxt[`IRQW_STS_TO] = 1'b0;
          sts_nxt[`IRQW_STS_PD] = 1'b0;
        end else if (any_en) begin
          state_nxt = irqw_pkg::IRQW_RUN;
          wake_nxt  = 1'b1;
          sts_nxt[`IRQW_STS_TO] = 1'b1;
          sts_nxt[`IRQW_STS_PD] = 1'b0;
        end
      end
      default: state_nxt = irqw_pkg::IRQW_RUN;
    endcase
    pend_nxt = ctl_r[`IRQW_GIE] && any_en;
    push_nxt = take;
    pcl_nxt  = take;
    pcv_nxt  = take ? `IRQW_PC_VECTOR : pcv_r;
    if (rst) begin
      state_nxt = irqw_pkg::IRQW_RUN;
      wake_nxt  = 1'b0;
      pend_nxt  = 1'b0;
      push_nxt  = 1'b0;
      pcl_nxt   = 1'b1;
      pcv_nxt   = `IRQW_PC_RESET;
      case (rst_kind)
        irqw_pkg::IRQW_RST_POR: begin
          sts_nxt = 8'h18;
          pwr_nxt = {3'b010, 1'b1};
        end
        irqw_pkg::IRQW_RST_MASTER_CLEAR_PIN: begin
          sts_nxt[7:5] = 3'b000;
          if (state_r == irqw_pkg::IRQW_SLEEP) begin
            sts_nxt[`IRQW_STS_TO] = 1'b1;
            sts_nxt[`IRQW_STS_PD] = 1'b0;
          end
          pwr_nxt[3] = 1'b0;
        end
        irqw_pkg::IRQW_RST_WDT: begin
          sts_nxt[7:4] = 4'h0;
          pwr_nxt[3]   = 1'b0;
        end
        irqw_pkg::IRQW_RST_BOR: begin
          sts_nxt[7:3] = 5'h03;
          pwr_nxt[3:2] = 2'b01;
          pwr_nxt[0]   = 1'b0;
        end
        default: sts_nxt = sts_r;
      endcase
    end
    slp_nxt = (state_nxt == irqw_pkg::IRQW_SLEEP);
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
    sts_r   <= sts_nxt;
    pwr_r   <= pwr_nxt;
    wake_r  <= wake_nxt;
    pend_r  <= pend_nxt;
    push_r  <= push_nxt;
    pcl_r   <= pcl_nxt;
    pcv_r   <= pcv_nxt;
    slp_r   <= slp_nxt;
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq_pending     = pend_r;
  assign stack_push      = push_r;
  assign pc_load         = pcl_r;
  assign pc_value        = pcv_r;
  assign core_wake       = wake_r;
  assign core_asleep     = slp_r;

  property p_gie_reset;
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> !ctl_r[`IRQW_GIE] && pcl_r && pcv_r == 13'h0000;
  endproperty
  a_gie_reset: assert property (p_gie_reset)
    else $error("reset left global enable set or pc not zero");

  property p_vector;
    @(posedge clock) disable iff (rst)
    push_r |-> pcl_r && pcv_r == 13'h0004 && !ctl_r[`IRQW_GIE] &&
               $past(ctl_r[`IRQW_GIE]);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector take without clear and vector load");

  property p_return_from_irq_instr;
    @(posedge clock) disable iff (rst)
    return_from_irq_instr |=> ctl_r[`IRQW_GIE];
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr)
    else $error("return did not set global enable");

  property p_gie_blocks;
    @(posedge clock) disable iff (rst)
    !ctl_r[`IRQW_GIE] |=> !push_r;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("request taken while global enable clear");

  property p_clr_next;
    @(posedge clock) disable iff (rst)
    gie_clr_now |=> !push_r ##1 !push_r;
  endproperty
  a_clr_next: assert property (p_clr_next)
    else $error("request taken after global enable cleared");

  property p_pin_flag;
    @(posedge clock) disable iff (rst)
    $rose(pins_s[8]) && cfg_r[`IRQW_CFG_EDGE] |=> ctl_r[`IRQW_PIN_IRQ_FLAG];
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("rising pin edge did not set pin flag");

  property p_t0_flag;
    @(posedge clock) disable iff (rst)
    t0_wrap |=> ctl_r[`IRQW_TIMER0_WRAP_FLAG];
  endproperty
  a_t0_flag: assert property (p_t0_flag)
    else $error("timer0 wrap did not set its flag");

  property p_wake;
    @(posedge clock) disable iff (rst)
    state_r == irqw_pkg::IRQW_SLEEP && any_en |=> core_wake && !slp_r;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled flag did not wake the core");

  property p_bor_pwr;
    @(posedge clock) disable iff (rst)
    $fell(rst) && $past(rst_kind) == irqw_pkg::IRQW_RST_BOR |->
      pwr_r[3:2] == 2'b01 && !pwr_r[0] && sts_r[7:3] == 5'h03;
  endproperty
  a_bor_pwr: assert property (p_bor_pwr)
    else $error("brown-out reset pattern wrong");

  property p_pend;
    @(posedge clock) disable iff (rst)
    ctl_r[`IRQW_GIE] && any_en |=> irq_pending;
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending request not raised");

endmodule

`default_nettype wire

//--- hdl/irqw_consts.svh
// Purpose: Offsets, field positions, reset values and fixed addresses
// Assumes: Included by the interrupt and wake control design files
// Notes:   Definitions only
`ifndef IRQW_CONSTS_SVH
`define IRQW_CONSTS_SVH

`define IRQW_ADR_CTL     6'h00
`define IRQW_ADR_FLA     6'h04
`define IRQW_ADR_FLB     6'h08
`define IRQW_ADR_ENA     6'h0C
`define IRQW_ADR_ENB     6'h10
`define IRQW_ADR_PWR     6'h14
`define IRQW_ADR_STS     6'h18
`define IRQW_ADR_CFG     6'h1C
`define IRQW_ADR_TMR     6'h20

`define IRQW_GIE         7
`define IRQW_PEIE        6
`define IRQW_T0IE        5
`define IRQW_INTE        4
`define IRQW_RBIE        3
`define IRQW_TIMER0_WRAP_FLAG        2
`define IRQW_PIN_IRQ_FLAG        1
`define IRQW_RBIF        0

`define IRQW_FLA_MASK    8'h7F
`define IRQW_FLB_MASK    8'hFD
`define IRQW_CTL_RST     8'h00
`define IRQW_CFG_RST     9'h100
`define IRQW_CFG_EDGE    8
`define IRQW_STS_TO      4
`define IRQW_STS_PD      3
`define IRQW_STS_WMASK   8'hE7

`define IRQW_PC_RESET    13'h0000
`define IRQW_PC_VECTOR   13'h0004

`endif

//--- hdl/irqw_pkg.sv
// Purpose: Types shared by the interrupt and wake control files
// Assumes: Nothing
// Notes:   Constants live in irqw_consts.svh
package irqw_pkg;

  typedef enum logic [1:0] {
    IRQW_RST_POR,
    IRQW_RST_MASTER_CLEAR_PIN,
    IRQW_RST_WDT,
    IRQW_RST_BOR
  } irqw_rst_kind_t;

  typedef enum logic {
    IRQW_RUN,
    IRQW_SLEEP
  } irqw_state_t;

endpackage

//--- hdl/irqw_sync.sv
// Purpose: Multi-stage synchroniser for asynchronous pin inputs
// Assumes: One clock, synchronous active-high reset
// Notes:   Only the last stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module irqw_sync #(
  parameter int W      = 9,
  parameter int STAGES = 2
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stg_r   [STAGES];
  logic [W-1:0] stg_nxt [STAGES];

  if (STAGES < 2 || W < 1) begin : g_chk
    $error("irqw_sync needs at least two stages and one bit");
  end

  always_comb begin
    stg_nxt[0] = rst ? '0 : async_in;
    for (int i = 1; i < STAGES; i++) begin
      stg_nxt[i] = rst ? '0 : stg_r[i-1];
    end
  end

  always_ff @(posedge clock) begin
    stg_r <= stg_nxt;
  end

  assign sync_out = stg_r[STAGES-1];

endmodule

`default_nettype wire

//--- hdl/irqw_timer0.sv
// Purpose: Free counter with load and a one-cycle wrap pulse
// Assumes: Tick is a one-cycle enable on the same clock
// Notes:   Wrap marks the all-ones to zero step
`timescale 1ns/1ps
`default_nettype none

module irqw_timer0 #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count,
  output logic              wrap
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         wrap_r;
  logic         wrap_nxt;

  if (W < 2) begin : g_chk
    $error("irqw_timer0 needs at least two bits");
  end

  always_comb begin
    count_nxt = count_r;
    wrap_nxt  = 1'b0;
    if (rst) begin
      count_nxt = '0;
    end else if (load) begin
      count_nxt = load_val;
    end else if (tick) begin
      count_nxt = count_r + 1'b1;
      wrap_nxt  = &count_r;
    end
  end

  always_ff @(posedge clock) begin
    count_r <= count_nxt;
    wrap_r  <= wrap_nxt;
  end

  assign count = count_r;
  assign wrap  = wrap_r;

endmodule

`default_nettype wire

//--- bench/irqw_core_model.sv
// Purpose: Core model giving instruction boundaries and core pulses
// Assumes: One clock; bench requests are one-cycle pulses
// Notes:   Slow mode spaces boundaries like two-cycle instructions
`timescale 1ns/1ps
`default_nettype none

module irqw_core_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic do_sleep,
  input  wire logic do_ret,
  input  wire logic core_asleep,
  output var  logic instr_boundary,
  output var  logic return_from_irq_instr,
  output var  logic sleep_enter
);
  logic phase_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_r               <= 1'b0;
      instr_boundary        <= 1'b0;
      return_from_irq_instr <= 1'b0;
      sleep_enter           <= 1'b0;
    end else begin
      phase_r               <= slow ? ~phase_r : 1'b0;
      // No instruction completes while asleep
      instr_boundary        <= ~core_asleep & ~phase_r;
      return_from_irq_instr <= do_ret;
      sleep_enter           <= do_sleep;
    end
  end
endmodule
`default_nettype wire

//--- bench/irqw_top_tb.sv
// Purpose: Self-checking bench for the interrupt and wake control block
// Assumes: Every bus access is answered with waitrequest low
// Notes:   Expected reads and vectors queue up for one monitor process
`timescale 1ns/1ps
`default_nettype none
`include "irqw_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module irqw_top_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  irqw_pkg::irqw_rst_kind_t rst_kind = irqw_pkg::IRQW_RST_POR;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_irq_pin = 1'b0;
  logic [7:0]  portb_pins = 8'h00;
  logic        t0_tick = 1'b0;
  logic [7:0]  periph_evt_a = 8'h00;
  logic [7:0]  periph_evt_b = 8'h00;
  logic        wdt_wake = 1'b0;
  logic        slow = 1'b0;
  logic        do_sleep = 1'b0;
  logic        do_ret = 1'b0;
  logic        instr_boundary, return_from_irq_instr, sleep_enter;
  logic        irq_pending, stack_push, pc_load, core_wake, core_asleep;
  logic [12:0] pc_value;
  int          cmp_count = 0;
  int          err_count = 0;
  int          n;
  int          i;
  logic [31:0] rd_q[$];
  string       nm_q[$];
  logic [12:0] pc_q[$];
  logic [31:0] m_e;
  string       m_s;
  logic [12:0] m_p;
  logic [7:0]  ev_a, ev_b;
  logic        lat_ok;
  irqw_pkg::irqw_rst_kind_t kinds [4] = '{irqw_pkg::IRQW_RST_WDT,
    irqw_pkg::IRQW_RST_BOR, irqw_pkg::IRQW_RST_MASTER_CLEAR_PIN, irqw_pkg::IRQW_RST_MASTER_CLEAR_PIN};
  logic [7:0]  sts_e [4] = '{8'h07, 8'h1F, 8'h1F, 8'h17};
  logic [3:0]  pw_e [4] = '{4'h5, 4'h4, 4'h4, 4'h4};

  irqw_top #(.SYNC_STAGES(2)) i_dut (
    .clock, .rst, .rst_kind, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_irq_pin,
    .portb_pins, .t0_tick, .periph_evt_a, .periph_evt_b, .instr_boundary,
    .return_from_irq_instr, .sleep_enter, .wdt_wake, .irq_pending,
    .stack_push, .pc_load, .pc_value, .core_wake, .core_asleep);

  irqw_core_model i_core (
    .clock, .rst, .slow, .do_sleep, .do_ret, .core_asleep, .instr_boundary,
    .return_from_irq_instr, .sleep_enter);

  always #20 clock = ~clock;

  // Oldest note is compared whenever a read or a program counter load lands
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      m_e = rd_q.pop_front();
      m_s = nm_q.pop_front();
      `CHK(m_s, m_e, avs_readdata)
    end
    if (!rst && pc_load === 1'b1) begin
      m_p = (pc_q.size() > 0) ? pc_q.pop_front() : 13'h1FFF;
      `CHK("pc_value", m_p, pc_value)
      `CHK("stack_push", (m_p == 13'h0004), stack_push)
    end
  end

  task automatic wait_hi(ref logic s);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (s !== 1'b1 && n < 200);
    if (n >= 200) err_count++;
  endtask

  task bus_wr(input logic [5:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task bus_rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    rd_q.push_back(e);
    nm_q.push_back(nm);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task do_reset(input irqw_pkg::irqw_rst_kind_t k, input int cyc);
    rst_kind <= k;
    rst      <= 1'b1;
    repeat (cyc) @(posedge clock);
    rst <= 1'b0;
    pc_q.push_back(13'h0000);
    @(posedge clock);
  endtask

  task pulse_core(input logic s, input logic r);
    do_sleep <= s;
    do_ret   <= r;
    @(posedge clock);
    do_sleep <= 1'b0;
    do_ret   <= 1'b0;
    @(posedge clock);
  endtask

  task pulse_evt(input logic [7:0] a, input logic [7:0] b);
    periph_evt_a <= a;
    periph_evt_b <= b;
    @(posedge clock);
    periph_evt_a <= 8'h00;
    periph_evt_b <= 8'h00;
    @(posedge clock);
  endtask

  task print_verdict();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hCEC938B9));
    do_reset(irqw_pkg::IRQW_RST_POR, 20);
    bus_rd(`IRQW_ADR_CTL, 32'h00, "ctl_por");
    bus_rd(`IRQW_ADR_STS, 32'h18, "sts_por");
    bus_rd(`IRQW_ADR_PWR, 32'h05, "pwr_por");
    bus_wr(6'h3C, 32'hFFFFFFFF);
    bus_rd(6'h3C, 32'h00, "unmapped");
    // Random events with every enable clear
    ev_a = 8'($urandom());
    ev_b = 8'($urandom());
    pulse_evt(ev_a, ev_b);
    bus_rd(`IRQW_ADR_FLA, {24'h0, ev_a & 8'h7F}, "fla");
    bus_rd(`IRQW_ADR_FLB, {24'h0, ev_b & 8'hFD}, "flb");
    bus_wr(`IRQW_ADR_ENA, 32'h7F);
    bus_rd(`IRQW_ADR_ENA, 32'h7F, "ena");
    bus_wr(`IRQW_ADR_ENB, 32'hFD);
    bus_rd(`IRQW_ADR_ENB, 32'hFD, "enb");
    `CHK("irq_pending", 1'b0, irq_pending)
    // One source taken, cleared by software, then returned
    bus_wr(`IRQW_ADR_FLA, 32'h00);
    bus_wr(`IRQW_ADR_FLB, 32'h00);
    bus_wr(`IRQW_ADR_ENB, 32'h00);
    bus_wr(`IRQW_ADR_ENA, 32'h01);
    pulse_evt(8'h01, 8'h00);
    pc_q.push_back(13'h0004);
    bus_wr(`IRQW_ADR_CTL, 32'hC0);
    wait_hi(stack_push);
    `CHK("irq_pending", 1'b1, irq_pending)
    bus_rd(`IRQW_ADR_CTL, 32'h40, "ctl_take");
    bus_wr(`IRQW_ADR_FLA, 32'h00);
    pulse_core(1'b0, 1'b1);
    bus_rd(`IRQW_ADR_CTL, 32'hC0, "ctl_ret");
    // Masked flag, then global enable clear, then slow core take
    pulse_evt(8'h02, 8'h00);
    repeat (4) @(posedge clock);
    `CHK("irq_pending", 1'b0, irq_pending)
    bus_wr(`IRQW_ADR_CTL, 32'h40);
    bus_wr(`IRQW_ADR_ENA, 32'h03);
    repeat (4) @(posedge clock);
    `CHK("irq_pending", 1'b0, irq_pending)
    slow <= 1'b1;
    pc_q.push_back(13'h0004);
    bus_wr(`IRQW_ADR_CTL, 32'hC0);
    wait_hi(stack_push);
    bus_wr(`IRQW_ADR_FLA, 32'h00);
    bus_wr(`IRQW_ADR_ENA, 32'h00);
    slow <= 1'b0;
    // Pin edge latency, timer0 wrap and port change
    bus_wr(`IRQW_ADR_CFG, 32'h101);
    bus_wr(`IRQW_ADR_CTL, 32'h90);
    pc_q.push_back(13'h0004);
    ext_irq_pin <= 1'b1;
    wait_hi(stack_push);
    lat_ok = (n - 1 >= 3) && (n - 1 <= 4);
    `CHK("latency", 1'b1, lat_ok)
    bus_wr(`IRQW_ADR_TMR, 32'hFF);
    t0_tick <= 1'b1;
    @(posedge clock);
    t0_tick    <= 1'b0;
    ev_b = 8'($urandom());
    portb_pins <= ev_b | 8'h01;
    repeat (4) @(posedge clock);
    bus_rd(`IRQW_ADR_CTL, 32'h17, "ctl_src");
    // Interrupt wake with global enable clear
    bus_wr(`IRQW_ADR_CFG, 32'h001);
    bus_wr(`IRQW_ADR_CTL, 32'h10);
    pulse_core(1'b1, 1'b0);
    wait_hi(core_asleep);
    ext_irq_pin <= 1'b0;
    wait_hi(core_wake);
    repeat (2) @(posedge clock);
    `CHK("core_asleep", 1'b0, core_asleep)
    bus_rd(`IRQW_ADR_CTL, 32'h12, "ctl_wake");
    bus_rd(`IRQW_ADR_STS, 32'h10, "sts_int_wake");
    // Interrupt wake with global enable set vectors after
    ext_irq_pin <= 1'b1;
    repeat (4) @(posedge clock);
    bus_wr(`IRQW_ADR_CTL, 32'h90);
    pulse_core(1'b1, 1'b0);
    wait_hi(core_asleep);
    pc_q.push_back(13'h0004);
    ext_irq_pin <= 1'b0;
    wait_hi(stack_push);
    bus_rd(`IRQW_ADR_CTL, 32'h12, "ctl_wake_vec");
    // Watchdog wake
    bus_wr(`IRQW_ADR_CTL, 32'h00);
    pulse_core(1'b1, 1'b0);
    wait_hi(core_asleep);
    wdt_wake <= 1'b1;
    @(posedge clock);
    wdt_wake <= 1'b0;
    wait_hi(core_wake);
    bus_rd(`IRQW_ADR_STS, 32'h00, "sts_wdt_wake");
    // Watchdog, brown-out and master clear resets, last master clear while asleep
    for (i = 0; i < 4; i++) begin
      bus_wr(`IRQW_ADR_CTL, 32'h80);
      bus_wr(`IRQW_ADR_STS, 32'hE7);
      if (i == 3) begin
        pulse_core(1'b1, 1'b0);
        wait_hi(core_asleep);
      end
      do_reset(kinds[i], 2);
      bus_rd(`IRQW_ADR_STS, {24'h0, sts_e[i]}, "sts_rst");
      bus_rd(`IRQW_ADR_PWR, {28'h0, pw_e[i]}, "pwr_rst");
      bus_rd(`IRQW_ADR_CTL, 32'h00, "ctl_rst");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
